// ==== sdcl_regs.svh ====
`ifndef SDCL_REGS_SVH
`define SDCL_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define SDCL_ADDR_CTRL       4'h0
`define SDCL_ADDR_STATUS     4'h4
`define SDCL_ADDR_SHIFT      4'h8

// Control register fields.
`define SDCL_CTRL_SOFT_CLR   0

// Status register field positions.
`define SDCL_ST_FB_LSB       0
`define SDCL_ST_OUT_LSB      9
`define SDCL_ST_TEST_LSB     12
`define SDCL_ST_MODE_LSB     14
`define SDCL_ST_PD_UP        16
`define SDCL_ST_PD_DN        17

// Serial shift register layout, first bit shifted in ends at the top.
`define SDCL_SH_LEN          14
`define SDCL_SH_TEST_LSB     12
`define SDCL_SH_OUT_LSB      9

// Reset values of the loaded configuration and of the control register.
`define SDCL_RST_FB          9'h0fa
`define SDCL_RST_OUT         3'h1
`define SDCL_RST_TEST        2'h0
`define SDCL_RST_CTRL        1'h0

// Reference pre-divider: counter width giving a divide by sixteen.
`define SDCL_REF_CNT_W       4

// Output divider periods in clock cycles, one clock standing for half an oscillator cycle.
`define SDCL_OUT_P0          5'h03
`define SDCL_OUT_P1          5'h04
`define SDCL_OUT_P2          5'h06
`define SDCL_OUT_P3          5'h08
`define SDCL_OUT_P4          5'h0c
`define SDCL_OUT_P5          5'h10

// AXI4-Lite responses.
`define SDCL_RESP_OKAY       2'h0
`define SDCL_RESP_SLVERR     2'h2

`endif

// ==== sdcl_pkg.sv ====
package sdcl_pkg;

    // Load mode, Gray coded along parallel -> latched -> serial.
    typedef enum logic [1:0] {
        SDCL_MODE_PAR    = 2'h0,
        SDCL_MODE_PLATCH = 2'h1,
        SDCL_MODE_SER    = 2'h3
    } sdcl_mode_t;

    typedef enum logic [1:0] {
        SDCL_WR_IDLE = 2'h0,
        SDCL_WR_RESP = 2'h1
    } sdcl_wr_t;

    typedef enum logic [1:0] {
        SDCL_RD_IDLE = 2'h0,
        SDCL_RD_DATA = 2'h1
    } sdcl_rd_t;

endpackage : sdcl_pkg

// ==== sdcl_top.sv ====
// Our own choices: register access over AXI4-Lite and the address map.
`include "sdcl_regs.svh"

module sdcl_top (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        parallel_latch_n,
    input  wire logic [8:0]  feedback_divider_bits,
    input  wire logic [2:0]  output_divider_bits,
    input  wire logic        serial_clock,
    input  wire logic        serial_data,
    input  wire logic        serial_load,
    input  wire logic        master_clear,
    input  wire logic        ref_source_select,
    input  wire logic        crystal_ref,
    input  wire logic        test_ref,
    input  wire logic        loop_bypass_select,
    output logic             synth_out_a,
    output logic             synth_out_a_n,
    output logic             synth_out_b,
    output logic             synth_out_b_n,
    output logic             monitor_out,
    output logic             ref_div_out,
    output logic             phase_up,
    output logic             phase_dn
);

    // Previous pin levels for edge detection.
    logic                    pl_d_r, sclk_d_r, sld_d_r, ref_d_r;
    logic                    pl_rise, sclk_rise, sld_rise, ref_lvl, ref_edge;
    logic [8:0]              fb_r, fb_nxt;
    logic [2:0]              out_code_r, out_code_nxt;
    logic [1:0]              test_r, test_nxt;
    logic [13:0]             shreg_r, shreg_nxt;
    sdcl_pkg::sdcl_mode_t    mode_r, mode_nxt;
    logic                    ctrl_clr_r, ctrl_clr_nxt;
    logic [3:0]              ref_cnt_r, ref_cnt_nxt;
    logic                    ref_div_r, ref_div_nxt;
    logic [8:0]              fb_cnt_r, fb_cnt_nxt;
    logic                    fb_out_r, fb_out_nxt;
    logic [4:0]              out_cnt_r, out_cnt_nxt, out_period;
    logic                    out_r, out_nxt, outn_r, outn_nxt, tick, clr;
    logic                    pd_up_r, pd_up_nxt, pd_dn_r, pd_dn_nxt, mon_r, mon_nxt;
    sdcl_pkg::sdcl_wr_t      wst_r, wst_nxt;
    sdcl_pkg::sdcl_rd_t      rst_r, rst_nxt;
    logic                    aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [3:0]              awaddr_r, awaddr_nxt;
    logic [31:0]             wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_word;
    logic [3:0]              wstrb_r, wstrb_nxt;
    logic [1:0]              bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic                    rd_hit;

    assign ref_lvl   = ref_source_select ? crystal_ref : test_ref;
    assign ref_edge  = ref_lvl & ~ref_d_r;
    assign pl_rise   = parallel_latch_n & ~pl_d_r;
    assign sclk_rise = serial_clock & ~sclk_d_r;
    assign sld_rise  = serial_load & ~sld_d_r;
    assign clr       = master_clear | ctrl_clr_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pl_d_r   <= 1'b0;
            sclk_d_r <= 1'b0;
            sld_d_r  <= 1'b0;
            ref_d_r  <= 1'b0;
        end else begin
            pl_d_r   <= parallel_latch_n;
            sclk_d_r <= serial_clock;
            sld_d_r  <= serial_load;
            ref_d_r  <= ref_lvl;
        end
    end

    // Configuration loading. Master clear deliberately does not touch this group.
    always_comb begin
        fb_nxt       = fb_r;
        out_code_nxt = out_code_r;
        test_nxt     = test_r;
        shreg_nxt    = shreg_r;
        mode_nxt     = mode_r;
        if (!parallel_latch_n) begin
            fb_nxt       = feedback_divider_bits;
            out_code_nxt = output_divider_bits;
            mode_nxt     = sdcl_pkg::SDCL_MODE_PAR;
        end else if (pl_rise) begin
            fb_nxt       = feedback_divider_bits;
            out_code_nxt = output_divider_bits;
            mode_nxt     = sdcl_pkg::SDCL_MODE_PLATCH;
        end else begin
            if (sclk_rise) begin
                // serial shift, first bit ends on top
                shreg_nxt = {shreg_r[`SDCL_SH_LEN-2:0], serial_data};
            end
            // strobe low or falling holds values
            if (sld_rise || (serial_load && sclk_rise)) begin
                fb_nxt       = shreg_nxt[8:0];
                out_code_nxt = shreg_nxt[`SDCL_SH_OUT_LSB +: 3];
                test_nxt     = shreg_nxt[`SDCL_SH_TEST_LSB +: 2];
                mode_nxt     = sdcl_pkg::SDCL_MODE_SER;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fb_r       <= `SDCL_RST_FB;
            out_code_r <= `SDCL_RST_OUT;
            test_r     <= `SDCL_RST_TEST;
            shreg_r    <= 14'h0000;
            mode_r     <= sdcl_pkg::SDCL_MODE_PAR;
        end else begin
            fb_r       <= fb_nxt;
            out_code_r <= out_code_nxt;
            test_r     <= test_nxt;
            shreg_r    <= shreg_nxt;
            mode_r     <= mode_nxt;
        end
    end

    always_comb begin
        case (out_code_r)
            3'h0:    out_period = `SDCL_OUT_P0;
            3'h1:    out_period = `SDCL_OUT_P1;
            3'h2:    out_period = `SDCL_OUT_P2;
            3'h3:    out_period = `SDCL_OUT_P3;
            3'h4:    out_period = `SDCL_OUT_P4;
            default: out_period = `SDCL_OUT_P5;
        endcase
    end

    // The system clock stands in for the oscillator; with ratio 1.5 the period is three clocks,
    // so that one setting cannot reach an exact half-high output.
    always_comb begin
        ref_cnt_nxt = ref_cnt_r;
        fb_cnt_nxt  = fb_cnt_r;
        out_cnt_nxt = out_cnt_r;
        pd_up_nxt   = pd_up_r;
        pd_dn_nxt   = pd_dn_r;
        tick        = loop_bypass_select | ref_edge;
        if (ref_edge) begin
            ref_cnt_nxt = ref_cnt_r + 4'h1;
        end
        fb_cnt_nxt = (fb_cnt_r >= fb_r - 9'h001) ? 9'h000 : fb_cnt_r + 9'h001;
        if (tick) begin
            out_cnt_nxt = (out_cnt_r >= out_period - 5'h01) ? 5'h00 : out_cnt_r + 5'h01;
        end
        if (clr) begin
            ref_cnt_nxt = 4'h0;
            fb_cnt_nxt  = 9'h000;
            out_cnt_nxt = 5'h00;
        end
        ref_div_nxt = ref_cnt_nxt[`SDCL_REF_CNT_W-1];
        fb_out_nxt  = fb_cnt_nxt < {1'b0, fb_r[8:1]};
        out_nxt     = ~clr & (out_cnt_nxt < {1'b0, out_period[4:1]});
        outn_nxt    = ~out_nxt;
        // Phase detector: which divided edge came first.
        if (clr) begin
            pd_up_nxt = 1'b0;
            pd_dn_nxt = 1'b0;
        end else if (ref_div_nxt && !ref_div_r && !(fb_out_nxt && !fb_out_r)) begin
            pd_up_nxt = 1'b1;
            pd_dn_nxt = 1'b0;
        end else if (fb_out_nxt && !fb_out_r && !(ref_div_nxt && !ref_div_r)) begin
            pd_up_nxt = 1'b0;
            pd_dn_nxt = 1'b1;
        end else if (ref_div_nxt && !ref_div_r) begin
            pd_up_nxt = 1'b0;
            pd_dn_nxt = 1'b0;
        end
        case (test_r)
            2'h0:    mon_nxt = 1'b0;
            2'h1:    mon_nxt = serial_data;
            2'h2:    mon_nxt = fb_out_r;
            default: mon_nxt = out_r;
        endcase
        if (mode_r != sdcl_pkg::SDCL_MODE_SER) begin
            mon_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ref_cnt_r <= 4'h0;
            ref_div_r <= 1'b0;
            fb_cnt_r  <= 9'h000;
            fb_out_r  <= 1'b0;
            out_cnt_r <= 5'h00;
            out_r     <= 1'b0;
            outn_r    <= 1'b1;
            pd_up_r   <= 1'b0;
            pd_dn_r   <= 1'b0;
            mon_r     <= 1'b0;
        end else begin
            ref_cnt_r <= ref_cnt_nxt;
            ref_div_r <= ref_div_nxt;
            fb_cnt_r  <= fb_cnt_nxt;
            fb_out_r  <= fb_out_nxt;
            out_cnt_r <= out_cnt_nxt;
            out_r     <= out_nxt;
            outn_r    <= outn_nxt;
            pd_up_r   <= pd_up_nxt;
            pd_dn_r   <= pd_dn_nxt;
            mon_r     <= mon_nxt;
        end
    end

    assign synth_out_a   = out_r;
    assign synth_out_b   = out_r;
    assign synth_out_a_n = outn_r;
    assign synth_out_b_n = outn_r;
    assign monitor_out   = mon_r;
    assign ref_div_out   = ref_div_r;
    assign phase_up      = pd_up_r;
    assign phase_dn      = pd_dn_r;

    // AXI4-Lite slave: address and data are taken in either order, one write and one read at a time.
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SDCL_ADDR_CTRL:   rd_word = {31'h00000000, ctrl_clr_r};
            `SDCL_ADDR_STATUS: rd_word = {14'h0000, pd_dn_r, pd_up_r, mode_r, test_r, out_code_r, fb_r};
            `SDCL_ADDR_SHIFT:  rd_word = {18'h00000, shreg_r};
            default: begin
                rd_word = 32'h00000000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always_comb begin
        wst_nxt      = wst_r;
        rst_nxt      = rst_r;
        aw_got_nxt   = aw_got_r;
        w_got_nxt    = w_got_r;
        awaddr_nxt   = awaddr_r;
        wdata_nxt    = wdata_r;
        wstrb_nxt    = wstrb_r;
        bresp_nxt    = bresp_r;
        rdata_nxt    = rdata_r;
        rresp_nxt    = rresp_r;
        ctrl_clr_nxt = ctrl_clr_r;
        case (wst_r)
            sdcl_pkg::SDCL_WR_IDLE: begin
                if (s_axi_awvalid && !aw_got_r) begin
                    aw_got_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_got_r) begin
                    w_got_nxt = 1'b1;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
                if (aw_got_r && w_got_r) begin
                    aw_got_nxt = 1'b0;
                    w_got_nxt  = 1'b0;
                    wst_nxt    = sdcl_pkg::SDCL_WR_RESP;
                    bresp_nxt  = `SDCL_RESP_OKAY;
                    case (awaddr_r)
                        `SDCL_ADDR_CTRL: begin
                            if (wstrb_r[0]) begin
                                ctrl_clr_nxt = wdata_r[`SDCL_CTRL_SOFT_CLR];
                            end
                        end
                        `SDCL_ADDR_STATUS, `SDCL_ADDR_SHIFT: ;
                        default: bresp_nxt = `SDCL_RESP_SLVERR;
                    endcase
                end
            end
            sdcl_pkg::SDCL_WR_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = sdcl_pkg::SDCL_WR_IDLE;
                end
            end
            default: wst_nxt = sdcl_pkg::SDCL_WR_IDLE;
        endcase
        case (rst_r)
            sdcl_pkg::SDCL_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rdata_nxt = rd_word;
                    rresp_nxt = rd_hit ? `SDCL_RESP_OKAY : `SDCL_RESP_SLVERR;
                    rst_nxt   = sdcl_pkg::SDCL_RD_DATA;
                end
            end
            sdcl_pkg::SDCL_RD_DATA: begin
                if (s_axi_rready) begin
                    rst_nxt = sdcl_pkg::SDCL_RD_IDLE;
                end
            end
            default: rst_nxt = sdcl_pkg::SDCL_RD_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wst_r      <= sdcl_pkg::SDCL_WR_IDLE;
            rst_r      <= sdcl_pkg::SDCL_RD_IDLE;
            aw_got_r   <= 1'b0;
            w_got_r    <= 1'b0;
            awaddr_r   <= 4'h0;
            wdata_r    <= 32'h00000000;
            wstrb_r    <= 4'h0;
            bresp_r    <= `SDCL_RESP_OKAY;
            rdata_r    <= 32'h00000000;
            rresp_r    <= `SDCL_RESP_OKAY;
            ctrl_clr_r <= `SDCL_RST_CTRL;
        end else begin
            wst_r      <= wst_nxt;
            rst_r      <= rst_nxt;
            aw_got_r   <= aw_got_nxt;
            w_got_r    <= w_got_nxt;
            awaddr_r   <= awaddr_nxt;
            wdata_r    <= wdata_nxt;
            wstrb_r    <= wstrb_nxt;
            bresp_r    <= bresp_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
            ctrl_clr_r <= ctrl_clr_nxt;
        end
    end

    // Ready flags are flops so that every bus output comes from a register.
    logic awready_r, wready_r, arready_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            arready_r <= 1'b0;
        end else begin
            awready_r <= (wst_nxt == sdcl_pkg::SDCL_WR_IDLE) && !aw_got_nxt;
            wready_r  <= (wst_nxt == sdcl_pkg::SDCL_WR_IDLE) && !w_got_nxt;
            arready_r <= (rst_nxt == sdcl_pkg::SDCL_RD_IDLE);
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_arready = arready_r;
    assign s_axi_bvalid  = wst_r[0];
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rst_r[0];
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

endmodule : sdcl_top

// ==== sdcl_ctrl_model.sv ====
module sdcl_ctrl_model (
    input  wire logic       clock,
    output logic            parallel_latch_n,
    output logic [8:0]      feedback_divider_bits,
    output logic [2:0]      output_divider_bits,
    output logic            serial_clock,
    output logic            serial_data,
    output logic            serial_load
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clocks per serial clock phase; the bench raises it to act as a slow controller.
    int half = 1;

    initial begin
        parallel_latch_n      = 1'b0;
        feedback_divider_bits = 9'h0fa;
        output_divider_bits   = 3'h1;
        serial_clock          = 1'b0;
        serial_data           = 1'b0;
        serial_load           = 1'b0;
    end

    task automatic par_set(input logic [8:0] fb, input logic [2:0] oc, input logic latch_n);
        @(posedge clock);
        feedback_divider_bits <= fb;
        output_divider_bits   <= oc;
        parallel_latch_n      <= latch_n;
        repeat (3) @(posedge clock);
    endtask : par_set

    task automatic shift_word(input logic [13:0] w);
        for (int i = 13; i >= 0; i--) begin
            @(posedge clock);
            serial_data <= w[i];
            repeat (half) @(posedge clock);
            serial_clock <= 1'b1;
            repeat (half) @(posedge clock);
            serial_clock <= 1'b0;
        end
        // The model drives the data pin low again once the frame is over.
        @(posedge clock);
        serial_data <= 1'b0;
    endtask : shift_word

    task automatic strobe(input logic lvl);
        @(posedge clock);
        serial_load <= lvl;
        repeat (3) @(posedge clock);
    endtask : strobe

    task automatic data_level(input logic v);
        @(posedge clock);
        serial_data <= v;
        repeat (3) @(posedge clock);
    endtask : data_level
endmodule : sdcl_ctrl_model

// ==== sdcl_asserts.sv ====
module sdcl_asserts (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        parallel_latch_n,
    input wire logic        master_clear,
    input wire logic        synth_out_a,
    input wire logic        synth_out_a_n,
    input wire logic        synth_out_b,
    input wire logic        synth_out_b_n,
    input wire logic        monitor_out,
    input wire logic        phase_up,
    input wire logic        phase_dn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence par_held;
        !parallel_latch_n [*4];
    endsequence
    sequence clr_held;
        master_clear [*3];
    endsequence

    a_mon_par_low: assert property (par_held |-> !monitor_out)
        else $error("monitor output active in parallel mode");
    a_clr_true_low: assert property (clr_held |-> !synth_out_a && !synth_out_b && !phase_up && !phase_dn)
        else $error("true outputs or phase flags not low under master clear");
    a_clr_inv_high: assert property (clr_held |-> synth_out_a_n && synth_out_b_n)
        else $error("inverted outputs not high under master clear");
    a_diff_pair: assert property (synth_out_a != synth_out_a_n && synth_out_b != synth_out_b_n)
        else $error("differential output halves agree");
    a_out_twins: assert property (synth_out_a == synth_out_b)
        else $error("the two synthesizer outputs differ");
    a_phase_excl: assert property (!(phase_up && phase_dn))
        else $error("phase detector drives up and down together");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not valid one cycle after address");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before taken");
endmodule : sdcl_asserts

bind sdcl_top sdcl_asserts i_sdcl_asserts (
    .clock(clock), .nrst(nrst), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .parallel_latch_n(parallel_latch_n), .master_clear(master_clear), .synth_out_a(synth_out_a),
    .synth_out_a_n(synth_out_a_n), .synth_out_b(synth_out_b), .synth_out_b_n(synth_out_b_n),
    .monitor_out(monitor_out), .phase_up(phase_up), .phase_dn(phase_dn)
);

// ==== sdcl_tb_top.sv ====
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
end

module sdcl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, nrst = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, last;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, tcnt = 2'h0;
    logic [3:0]  strb = 4'hf;
    logic        pl_n, sclk, sdat, sload, mclr = 1'b0, rsel = 1'b1, bsel = 1'b1;
    logic        out_a, out_an, out_b, out_bn, mon, refdiv, pup, pdn;
    logic [8:0]  fbp, f;
    logic [2:0]  ocp, o;
    logic [13:0] w;
    logic [65:0] rd_q[$];
    logic [1:0]  wr_q[$];
    int          fails = 0, num_checks = 0, cyc = 0, per, hi;
    int          tbl[8] = '{3, 4, 6, 8, 12, 16, 16, 16};

    sdcl_top i_sdcl_top (
        .clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .parallel_latch_n(pl_n), .feedback_divider_bits(fbp),
        .output_divider_bits(ocp), .serial_clock(sclk), .serial_data(sdat), .serial_load(sload),
        .master_clear(mclr), .ref_source_select(rsel), .crystal_ref(tcnt[0]), .test_ref(tcnt[1]),
        .loop_bypass_select(bsel), .synth_out_a(out_a), .synth_out_a_n(out_an), .synth_out_b(out_b),
        .synth_out_b_n(out_bn), .monitor_out(mon), .ref_div_out(refdiv), .phase_up(pup), .phase_dn(pdn)
    );
    sdcl_ctrl_model i_sdcl_ctrl_model (
        .clock(clock), .parallel_latch_n(pl_n), .feedback_divider_bits(fbp), .output_divider_bits(ocp),
        .serial_clock(sclk), .serial_data(sdat), .serial_load(sload)
    );

    initial begin
        forever #50 clock = ~clock;
    end

    function automatic logic [31:0] sts(input logic [8:0] fb, input logic [2:0] oc, input logic [1:0] tt,
                                        input logic [1:0] md);
        return {16'h0, md, tt, oc, fb};
    endfunction : sts

    function automatic logic pick(input int s);
        return (s == 0) ? out_a : (s == 1) ? mon : refdiv;
    endfunction : pick

    task automatic end_sim();
        if (rd_q.size() + wr_q.size() != 0) fails++;
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
        rd_q.push_back({m, r, e & m});
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_done, w_done;
        wr_q.push_back(r);
        aw_done = 1'b0;
        w_done  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    // Counts the clocks of one whole period between two rising edges; the caller repeats it to skip a partial one.
    task automatic period(input int s, output int p, output int h);
        int   n;
        logic l, v;
        n = 0;
        p = 0;
        h = 0;
        l = pick(s);
        while (n < 2) begin
            @(posedge clock);
            v = pick(s);
            if (n == 1) p++;
            if (l === 1'b0 && v === 1'b1) n++;
            if (n == 1 && v === 1'b1) h++;
            l = v;
        end
    endtask : period

    always @(posedge clock) begin
        tcnt <= tcnt + 2'h1;
        if (rvalid && rready && rd_q.size() > 0) begin
            `CHK("rdata", rd_q[0][31:0], rdata & rd_q[0][65:34])
            `CHK("rresp", rd_q[0][33:32], rresp)
            void'(rd_q.pop_front());
        end
        if (bvalid && bready && wr_q.size() > 0) begin
            `CHK("bresp", wr_q[0], bresp)
            void'(wr_q.pop_front());
        end
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(72));
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(4'h4, sts(9'h0fa, 3'h1, 2'h0, 2'h0), 32'hffff, 2'h0);
        f = 9'd250 + 9'($urandom % 251);
        o = 3'($urandom);
        i_sdcl_ctrl_model.par_set(f, o, 1'b0);
        rd(4'h4, sts(f, o, 2'h0, 2'h0), 32'hffff, 2'h0);
        i_sdcl_ctrl_model.par_set(f, o, 1'b1);
        i_sdcl_ctrl_model.par_set(~f, ~o, 1'b1);
        rd(4'h4, sts(f, o, 2'h0, 2'h1), 32'hffff, 2'h0);
        for (int c = 0; c < 8; c++) begin
            i_sdcl_ctrl_model.par_set(f, 3'(c), 1'b0);
            repeat (2) period(0, per, hi);
            `CHK("out_period", tbl[c], per)
            `CHK("out_high", tbl[c] / 2, hi)
        end
        bsel <= 1'b0;
        repeat (2) period(0, per, hi);
        `CHK("bypass_period", 2 * tbl[7], per)
        bsel <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            rsel <= s[0];
            repeat (2) period(2, per, hi);
            `CHK("ref_period", 64 >> s, per)
            `CHK("ref_high", 32 >> s, hi)
        end
        i_sdcl_ctrl_model.par_set(f, 3'h7, 1'b1);
        last = sts(f, 3'h7, 2'h0, 2'h1);
        for (int t = 0; t < 4; t++) begin
            i_sdcl_ctrl_model.half = t + 1;
            f = 9'd250 + 9'($urandom % 251);
            o = 3'($urandom);
            w = {2'(t), o, f};
            i_sdcl_ctrl_model.shift_word(w);
            rd(4'h8, {18'h0, w}, 32'h3fff, 2'h0);
            rd(4'h4, last, 32'hffff, 2'h0);
            i_sdcl_ctrl_model.strobe(1'b1);
            i_sdcl_ctrl_model.strobe(1'b0);
            last = sts(f, o, 2'(t), 2'h3);
            rd(4'h4, last, 32'hffff, 2'h0);
            case (t)
                0: `CHK("mon_low", 1'b0, mon)
                1: begin
                    i_sdcl_ctrl_model.data_level(1'b1);
                    `CHK("mon_data", 1'b1, mon)
                    i_sdcl_ctrl_model.data_level(1'b0);
                end
                2: begin
                    repeat (2) period(1, per, hi);
                    `CHK("fb_period", int'(f), per)
                end
                default: begin
                    repeat (2) period(1, per, hi);
                    `CHK("mon_fout", tbl[o], per)
                end
            endcase
        end
        i_sdcl_ctrl_model.strobe(1'b1);
        i_sdcl_ctrl_model.shift_word({2'h3, 3'h2, 9'd500});
        rd(4'h4, sts(9'd500, 3'h2, 2'h3, 2'h3), 32'hffff, 2'h0);
        i_sdcl_ctrl_model.strobe(1'b0);
        i_sdcl_ctrl_model.par_set(9'd300, 3'h4, 1'b0);
        `CHK("mon_par", 1'b0, mon)
        rd(4'h4, sts(9'd300, 3'h4, 2'h3, 2'h0), 32'hffff, 2'h0);
        mclr <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("clr_outs", 4'h5, {out_a, out_an, out_b, out_bn})
        rd(4'h4, sts(9'd300, 3'h4, 2'h3, 2'h0), 32'hffff, 2'h0);
        mclr <= 1'b0;
        wr(4'h0, 32'h1, 2'h0);
        rd(4'h0, 32'h1, 32'h1, 2'h0);
        `CHK("soft_clr", 2'h1, {out_a, out_an})
        wr(4'h0, 32'h0, 2'h0);
        strb <= 4'($urandom) & 4'he;
        wr(4'h0, 32'h1, 2'h0);
        rd(4'h0, 32'h0, 32'h1, 2'h0);
        strb <= 4'hf;
        wr(4'h4, 32'h0, 2'h0);
        wr(4'hc, 32'h0, 2'h2);
        rd(4'h4, sts(9'd300, 3'h4, 2'h3, 2'h0), 32'hffff, 2'h0);
        rd(4'hc, 32'h0, 32'hffffffff, 2'h2);
        @(posedge clock);
        end_sim();
    end
endmodule : sdcl_tb_top
